// *** logic/ubt_pkg.sv ***
package ubt_pkg;
  // Word offsets on the Avalon-MM bus; byte address is four times the index.
  localparam logic [7:0] SERIAL_BUFFER_IDX   = 8'h99;
  localparam logic [7:0] BAUD_RELOAD_IDX     = 8'h9A;
  localparam logic [7:0] TIMER_TWO_CTRL_IDX  = 8'hC8;
  localparam logic [7:0] POWER_MODE_IDX      = 8'h87;
  localparam logic [7:0] BAUD_GEN_CTRL_IDX   = 8'h9B;
  localparam logic [7:0] SERIAL_CTRL_IDX     = 8'h98;
  localparam logic [7:0] TIMER_TWO_LOW_IDX   = 8'hCC;
  localparam logic [7:0] TIMER_TWO_HIGH_IDX  = 8'hCD;
  localparam logic [7:0] RELOAD_LOW_IDX      = 8'hCA;
  localparam logic [7:0] RELOAD_HIGH_IDX     = 8'hCB;
  localparam logic [7:0] SERIAL_STATUS_IDX   = 8'hA0;
  localparam logic [7:0] MODE_EXT_IDX        = 8'hA1;
  // Timer two control fields.
  localparam int T2_OVF_BIT   = 7;
  localparam int T2_EXT_BIT   = 6;
  localparam int RX_T2_BIT    = 5;
  localparam int TX_T2_BIT    = 4;
  localparam int TRIG_EN_BIT  = 3;
  localparam int T2_RUN_BIT   = 2;
  localparam int CT_SEL_BIT   = 1;
  localparam int CAP_SEL_BIT  = 0;
  // Power and mode control fields.
  localparam int BAUD_DBL_BIT = 7;
  localparam int FE_VIEW_BIT  = 6;
  localparam logic [7:0] POWER_MODE_WMASK = 8'hC0;
  // Baud generator control fields.
  localparam int BRG_RUN_BIT  = 4;
  localparam int TX_BRG_BIT   = 3;
  localparam int RX_BRG_BIT   = 2;
  localparam int BRG_FAST_BIT = 1;
  localparam int M0_SRC_BIT   = 0;
  localparam logic [7:0] BAUD_GEN_WMASK = 8'h1F;
  // Mode extension fields.
  localparam int UPDN_BIT     = 0;
  localparam int X2_BIT       = 1;
  // Serial control fields.
  localparam int SM0_BIT      = 7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Fixed dividers of the peripheral clock.
  localparam int M0_DIV_STD  = 12;
  localparam int M0_DIV_X2   = 6;
  localparam int BRG_SLOW_PRE = 2;
endpackage : ubt_pkg

// *** logic/ubt_core.sv ***
`timescale 1ns/10ps
// Overview of operation
// - Overflow flag sets on timer-two overflow only when no serial clock uses it.
// - Trigger-pin falling edge that captures or reloads sets external flag, software clears.
// - External flag raises no interrupt while up/down counting is enabled.
// - Modes 1 and 3 receive clock from timer two when selected, else timer one.
// - Modes 1 and 3 transmit clock from timer two when selected, else timer one.
// - Trigger enable gates pin edges; ignored while timer two clocks the serial port.
// - Timer two counts only while its run bit is set.
// - Select bit chooses peripheral clock or falling edges on count pin.
// - Any serial clock select forces auto-reload, ignoring capture select.
// - Capture select clear reloads on overflow and trigger; set captures on trigger.
// - Baud doubling bit doubles the rate in modes 1, 2 and 3.
// - Framing view bit makes serial control bit 7 show framing error or mode bit.
// - Internal baud generator runs only while its run bit is set.
// - Transmit generator select makes internal generator clock transmission.
// - Receive generator select makes internal generator clock reception.
// - Speed bit picks slow generator when clear, fast when set.
// - Mode 0 clocks at fixed divide or from internal generator per source bit.
// - Generator reloads from an 8-bit reload register reset to zero.
// - Serial buffer contents are undefined until the first transfer.
// - Framing error sets on bad stop bit, stays until software clears.
module ubt_core #(
  parameter int CNT_W = 16
) (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [1:0]       o_avs_response,
  input  wire logic        i_timer_two_trigger_pin,
  input  wire logic        i_timer_two_count_pin,
  input  wire logic        i_timer_one_overflow,
  input  wire logic [1:0]  i_serial_mode,
  input  wire logic        i_framing_error_set,
  input  wire logic        i_rx_byte_valid,
  input  wire logic [7:0]  i_rx_byte,
  output logic [7:0]       o_tx_byte,
  output logic             o_tx_load,
  output logic             o_tx_baud_tick,
  output logic             o_rx_baud_tick,
  output logic             o_baud_doubling,
  output logic             o_timer_two_irq
);
  typedef enum logic [1:0] {UBT_IDLE = 2'b01, UBT_ACK = 2'b10} ubt_bus_e;
  ubt_bus_e bus_r;
  logic [7:0] t2ctl_r, pmode_r, bgctl_r, brl_r, serial_buffer_r, serial_control_register_r, ext_r;
  logic [CNT_W-1:0] cnt_r, rld_r;
  logic [7:0] brg_cnt_r;
  logic brg_pre_r;
  logic [3:0] m0_cnt_r;
  logic fe_r, tx_load_r;
  logic [31:0] rdata_r;
  logic [1:0] resp_r;
  logic trg_s1_r, trg_s2_r, trg_s3_r, cnt_s1_r, cnt_s2_r, cnt_s3_r;
  logic [7:0] idx;
  logic acc, wr, rd, be0, mapped;
  logic t2_serial, trg_fall, cnt_fall, t2_inc, t2_ovf, ext_event, brg_tick, m0_tick;
  logic t2_low_wr, t2_high_wr, rl_low_wr, rl_high_wr;
  logic [3:0] m0_div;

  assign idx = i_avs_address[9:2];
  assign acc = (bus_r == UBT_IDLE) && (i_avs_read || i_avs_write);
  // Unmapped or misaligned accesses are still answered, but they change and return nothing.
  assign wr  = acc && i_avs_write && mapped;
  assign rd  = acc && i_avs_read && mapped;
  assign be0 = i_avs_byteenable[0];
  assign mapped = (i_avs_address[1:0] == 2'b00) &&
                  (idx inside {ubt_pkg::SERIAL_BUFFER_IDX, ubt_pkg::BAUD_RELOAD_IDX,
                   ubt_pkg::TIMER_TWO_CTRL_IDX, ubt_pkg::POWER_MODE_IDX, ubt_pkg::BAUD_GEN_CTRL_IDX,
                   ubt_pkg::SERIAL_CTRL_IDX, ubt_pkg::TIMER_TWO_LOW_IDX, ubt_pkg::TIMER_TWO_HIGH_IDX,
                   ubt_pkg::RELOAD_LOW_IDX, ubt_pkg::RELOAD_HIGH_IDX, ubt_pkg::SERIAL_STATUS_IDX,
                   ubt_pkg::MODE_EXT_IDX});
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (bus_r != UBT_ACK);
  assign o_avs_readdata = rdata_r;
  assign o_avs_response = resp_r;

  // Every access takes one extra cycle so read data always comes from a flop.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bus_r <= UBT_IDLE;
    end else begin
      unique case (bus_r)
        UBT_IDLE: begin
          if (acc) begin
            bus_r <= UBT_ACK;
          end
        end
        UBT_ACK: begin
          bus_r <= UBT_IDLE;
        end
        default: begin
          bus_r <= UBT_IDLE;
        end
      endcase
    end
  end

  // Pins come from outside the clock domain; the third stage feeds edge detection only.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trg_s1_r <= 1'b1;
      trg_s2_r <= 1'b1;
      trg_s3_r <= 1'b1;
      cnt_s1_r <= 1'b1;
      cnt_s2_r <= 1'b1;
      cnt_s3_r <= 1'b1;
    end else begin
      trg_s1_r <= i_timer_two_trigger_pin;
      trg_s2_r <= trg_s1_r;
      trg_s3_r <= trg_s2_r;
      cnt_s1_r <= i_timer_two_count_pin;
      cnt_s2_r <= cnt_s1_r;
      cnt_s3_r <= cnt_s2_r;
    end
  end

  assign trg_fall = trg_s3_r && !trg_s2_r;
  assign cnt_fall = cnt_s3_r && !cnt_s2_r;
  assign t2_serial = t2ctl_r[ubt_pkg::RX_T2_BIT] || t2ctl_r[ubt_pkg::TX_T2_BIT];
  assign t2_inc = t2ctl_r[ubt_pkg::T2_RUN_BIT] &&
                  (t2ctl_r[ubt_pkg::CT_SEL_BIT] ? cnt_fall : 1'b1);
  assign t2_ovf = t2_inc && (&cnt_r);
  assign ext_event = t2ctl_r[ubt_pkg::TRIG_EN_BIT] && trg_fall && !t2_serial;
  assign t2_low_wr  = wr && be0 && idx == ubt_pkg::TIMER_TWO_LOW_IDX;
  assign t2_high_wr = wr && be0 && idx == ubt_pkg::TIMER_TWO_HIGH_IDX;
  assign rl_low_wr  = wr && be0 && idx == ubt_pkg::RELOAD_LOW_IDX;
  assign rl_high_wr = wr && be0 && idx == ubt_pkg::RELOAD_HIGH_IDX;

  // Counter and capture/reload register of timer two.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= ubt_pkg::RESET_WORD;
      rld_r <= ubt_pkg::RESET_WORD;
    end else begin
      if (t2_low_wr) begin
        cnt_r[7:0] <= i_avs_writedata[7:0];
      end else if (t2_high_wr) begin
        cnt_r[CNT_W-1:8] <= i_avs_writedata[CNT_W-9:0];
      end else if (t2_ovf) begin
        cnt_r <= rld_r;
      end else if (ext_event && !(t2ctl_r[ubt_pkg::CAP_SEL_BIT] && !t2_serial)) begin
        cnt_r <= rld_r;
      end else if (t2_inc) begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (rl_low_wr) begin
        rld_r[7:0] <= i_avs_writedata[7:0];
      end else if (rl_high_wr) begin
        rld_r[CNT_W-1:8] <= i_avs_writedata[CNT_W-9:0];
      end else if (ext_event && t2ctl_r[ubt_pkg::CAP_SEL_BIT]) begin
        rld_r <= cnt_r;
      end
    end
  end

  // Control register; hardware flag sets win over a software clear in the same cycle.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      t2ctl_r <= ubt_pkg::RESET_BYTE;
    end else begin
      if (wr && be0 && idx == ubt_pkg::TIMER_TWO_CTRL_IDX) begin
        t2ctl_r <= i_avs_writedata[7:0];
      end
      if (t2_ovf && !t2_serial) begin
        t2ctl_r[ubt_pkg::T2_OVF_BIT] <= 1'b1;
      end
      if (ext_event) begin
        t2ctl_r[ubt_pkg::T2_EXT_BIT] <= 1'b1;
      end
    end
  end

  assign o_timer_two_irq = t2ctl_r[ubt_pkg::T2_OVF_BIT] ||
                           (t2ctl_r[ubt_pkg::T2_EXT_BIT] && !ext_r[ubt_pkg::UPDN_BIT]);

  // Software-owned configuration registers; reserved bits stay zero.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pmode_r <= ubt_pkg::RESET_BYTE;
      bgctl_r <= ubt_pkg::RESET_BYTE;
      brl_r   <= ubt_pkg::RESET_BYTE;
      ext_r   <= ubt_pkg::RESET_BYTE;
    end else if (wr && be0) begin
      unique case (idx)
        ubt_pkg::POWER_MODE_IDX:    pmode_r <= i_avs_writedata[7:0] & ubt_pkg::POWER_MODE_WMASK;
        ubt_pkg::BAUD_GEN_CTRL_IDX: bgctl_r <= i_avs_writedata[7:0] & ubt_pkg::BAUD_GEN_WMASK;
        ubt_pkg::BAUD_RELOAD_IDX:   brl_r   <= i_avs_writedata[7:0];
        ubt_pkg::MODE_EXT_IDX:      ext_r   <= i_avs_writedata[7:0] & 8'h03;
        default: ;
      endcase
    end
  end

  // The serial buffer has no reset; its content is meaningless until the first transfer.
  always_ff @(posedge i_mclk) begin
    if (i_rx_byte_valid) begin
      serial_buffer_r <= i_rx_byte;
    end else if (wr && be0 && idx == ubt_pkg::SERIAL_BUFFER_IDX) begin
      serial_buffer_r <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tx_load_r <= 1'b0;
    end else begin
      tx_load_r <= wr && be0 && idx == ubt_pkg::SERIAL_BUFFER_IDX;
    end
  end
  assign o_tx_byte = serial_buffer_r;
  assign o_tx_load = tx_load_r;

  // Serial control byte: bit 7 is the mode bit or the framing error, per view select.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      serial_control_register_r <= ubt_pkg::RESET_BYTE;
      fe_r   <= 1'b0;
    end else begin
      if (wr && be0 && idx == ubt_pkg::SERIAL_CTRL_IDX) begin
        if (pmode_r[ubt_pkg::FE_VIEW_BIT]) begin
          fe_r <= i_avs_writedata[ubt_pkg::SM0_BIT];
          serial_control_register_r[6:0] <= i_avs_writedata[6:0];
        end else begin
          serial_control_register_r <= i_avs_writedata[7:0];
        end
      end
      if (i_framing_error_set) begin
        fe_r <= 1'b1;
      end
    end
  end

  // Internal generator: 8-bit up-counter reloaded from the reload register.
  // Slow speed uses one extra divide-by-two prescaler stage.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      brg_cnt_r <= ubt_pkg::RESET_BYTE;
      brg_pre_r <= 1'b0;
    end else if (!bgctl_r[ubt_pkg::BRG_RUN_BIT]) begin
      brg_cnt_r <= brl_r;
      brg_pre_r <= 1'b0;
    end else begin
      brg_pre_r <= !brg_pre_r;
      if (bgctl_r[ubt_pkg::BRG_FAST_BIT] || brg_pre_r) begin
        brg_cnt_r <= (&brg_cnt_r) ? brl_r : brg_cnt_r + 8'h01;
      end
    end
  end
  assign brg_tick = bgctl_r[ubt_pkg::BRG_RUN_BIT] && (&brg_cnt_r) &&
                    (bgctl_r[ubt_pkg::BRG_FAST_BIT] || brg_pre_r);

  // Mode 0 fixed divider.
  assign m0_div = ext_r[ubt_pkg::X2_BIT] ? 4'(ubt_pkg::M0_DIV_X2) : 4'(ubt_pkg::M0_DIV_STD);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      m0_cnt_r <= 4'h0;
    end else if (m0_cnt_r >= m0_div - 4'h1) begin
      m0_cnt_r <= 4'h0;
    end else begin
      m0_cnt_r <= m0_cnt_r + 4'h1;
    end
  end
  assign m0_tick = (m0_cnt_r == m0_div - 4'h1);

  // Baud tick routing; the internal generator select wins over the timer choice.
  always_comb begin
    if (i_serial_mode == 2'b00) begin
      o_tx_baud_tick = bgctl_r[ubt_pkg::M0_SRC_BIT] ? brg_tick : m0_tick;
      o_rx_baud_tick = o_tx_baud_tick;
    end else if (i_serial_mode == 2'b10) begin
      o_tx_baud_tick = 1'b0;
      o_rx_baud_tick = 1'b0;
    end else begin
      if (bgctl_r[ubt_pkg::TX_BRG_BIT]) begin
        o_tx_baud_tick = brg_tick;
      end else begin
        o_tx_baud_tick = t2ctl_r[ubt_pkg::TX_T2_BIT] ? t2_ovf : i_timer_one_overflow;
      end
      if (bgctl_r[ubt_pkg::RX_BRG_BIT]) begin
        o_rx_baud_tick = brg_tick;
      end else begin
        o_rx_baud_tick = t2ctl_r[ubt_pkg::RX_T2_BIT] ? t2_ovf : i_timer_one_overflow;
      end
    end
  end
  assign o_baud_doubling = pmode_r[ubt_pkg::BAUD_DBL_BIT] && (i_serial_mode != 2'b00);

  // Read data and response registered in the accept cycle.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 32'h0000_0000;
      resp_r  <= 2'b00;
    end else if (acc) begin
      resp_r  <= mapped ? 2'b00 : 2'b11;
      rdata_r <= 32'h0000_0000;
      if (rd) begin
        unique case (idx)
          ubt_pkg::SERIAL_BUFFER_IDX:  rdata_r[7:0] <= serial_buffer_r;
          ubt_pkg::BAUD_RELOAD_IDX:    rdata_r[7:0] <= brl_r;
          ubt_pkg::TIMER_TWO_CTRL_IDX: rdata_r[7:0] <= t2ctl_r;
          ubt_pkg::POWER_MODE_IDX:     rdata_r[7:0] <= pmode_r;
          ubt_pkg::BAUD_GEN_CTRL_IDX:  rdata_r[7:0] <= bgctl_r;
          ubt_pkg::SERIAL_CTRL_IDX:    rdata_r[7:0] <= {pmode_r[ubt_pkg::FE_VIEW_BIT] ? fe_r :
                                                        serial_control_register_r[7], serial_control_register_r[6:0]};
          ubt_pkg::TIMER_TWO_LOW_IDX:  rdata_r[7:0] <= cnt_r[7:0];
          ubt_pkg::TIMER_TWO_HIGH_IDX: rdata_r[CNT_W-9:0] <= cnt_r[CNT_W-1:8];
          ubt_pkg::RELOAD_LOW_IDX:     rdata_r[7:0] <= rld_r[7:0];
          ubt_pkg::RELOAD_HIGH_IDX:    rdata_r[CNT_W-9:0] <= rld_r[CNT_W-1:8];
          ubt_pkg::SERIAL_STATUS_IDX:  rdata_r[7:0] <= {7'h00, fe_r};
          ubt_pkg::MODE_EXT_IDX:       rdata_r[7:0] <= ext_r;
          default: ;
        endcase
      end
    end
  end
endmodule : ubt_core

// *** testbench/ubt_core_sva.sv ***
`timescale 1ns/10ps
module ubt_core_sva (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic [9:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic [1:0]  o_avs_response,
  input wire logic        i_timer_one_overflow,
  input wire logic [1:0]  i_serial_mode,
  input wire logic [7:0]  o_tx_byte,
  input wire logic        o_tx_load,
  input wire logic        o_tx_baud_tick,
  input wire logic        o_rx_baud_tick,
  input wire logic        o_baud_doubling
);
  logic [7:0] gen_r;
  logic [7:0] t2c_r;
  logic       ack;
  logic       acc;
  logic       wok;
  logic [7:0] idx;
  assign ack = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  // The design takes a write at the edge where the request first meets waitrequest high.
  assign acc = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  assign wok = acc && i_avs_write && i_avs_address[1:0] == 2'h0;
  assign idx = i_avs_address[9:2];
  // Select bits are shadowed here because only the ports are visible to this checker.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      gen_r <= 8'h00;
      t2c_r <= 8'h00;
    end else if (wok && idx == ubt_pkg::BAUD_GEN_CTRL_IDX) begin
      gen_r <= i_avs_writedata[7:0];
    end else if (wok && idx == ubt_pkg::TIMER_TWO_CTRL_IDX) begin
      t2c_r <= i_avs_writedata[7:0];
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  AST_WAIT_ONE: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("access not answered after one wait cycle");
  AST_BAD_ADDR: assert property (ack && i_avs_address[1:0] != 2'h0 |-> o_avs_response == 2'h3)
    else $error("misaligned access not refused");
  AST_DBL: assert property (wok && idx == ubt_pkg::POWER_MODE_IDX |=> o_baud_doubling == ($past(i_avs_writedata[7]) && i_serial_mode != 2'h0))
    else $error("doubling output does not follow its bit");
  AST_TX_BYTE: assert property (wok && idx == ubt_pkg::SERIAL_BUFFER_IDX |=> o_tx_byte == $past(i_avs_writedata[7:0]) ##[0:1] o_tx_load)
    else $error("buffer write not handed to transmitter");
  AST_TX_T1: assert property (i_serial_mode[0] && !t2c_r[4] && !gen_r[3] |-> o_tx_baud_tick == i_timer_one_overflow)
    else $error("transmit tick not from timer one");
  AST_RX_T1: assert property (i_serial_mode[0] && !t2c_r[5] && !gen_r[2] |-> o_rx_baud_tick == i_timer_one_overflow)
    else $error("receive tick not from timer one");
  AST_TX_GEN_IDLE: assert property (i_serial_mode[0] && gen_r[3] && !gen_r[4] |-> !o_tx_baud_tick)
    else $error("transmit tick from a stopped generator");
  AST_RX_GEN_IDLE: assert property (i_serial_mode[0] && gen_r[2] && !gen_r[4] |-> !o_rx_baud_tick)
    else $error("receive tick from a stopped generator");
  COV_TX_GEN: cover property (o_tx_baud_tick && gen_r[3] && gen_r[4]);
  COV_RX_T2: cover property (o_rx_baud_tick && t2c_r[5]);
  COV_BUF: cover property (wok && idx == ubt_pkg::SERIAL_BUFFER_IDX);
endmodule : ubt_core_sva
bind ubt_core ubt_core_sva ubt_core_sva_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response), .o_tx_byte(o_tx_byte),
  .i_timer_one_overflow(i_timer_one_overflow), .i_serial_mode(i_serial_mode), .o_tx_load(o_tx_load),
  .o_tx_baud_tick(o_tx_baud_tick), .o_rx_baud_tick(o_rx_baud_tick), .o_baud_doubling(o_baud_doubling));

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] T2C = ubt_pkg::TIMER_TWO_CTRL_IDX;
  localparam logic [7:0] GEN = ubt_pkg::BAUD_GEN_CTRL_IDX;
  localparam logic [7:0] RLV = ubt_pkg::BAUD_RELOAD_IDX;
  localparam logic [7:0] PMC = ubt_pkg::POWER_MODE_IDX;
  localparam logic [7:0] CNL = ubt_pkg::TIMER_TWO_LOW_IDX;
  localparam logic [7:0] RLL = ubt_pkg::RELOAD_LOW_IDX;
  localparam logic [7:0] MEX = ubt_pkg::MODE_EXT_IDX;
  localparam logic [7:0] SCR = ubt_pkg::SERIAL_CTRL_IDX;
  logic        i_mclk = 1'h0;
  logic        i_rst = 1'h1;
  logic [9:0]  i_avs_address = 10'h000;
  logic        i_avs_read = 1'h0;
  logic        i_avs_write = 1'h0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic        i_timer_two_trigger_pin = 1'h1;
  logic        i_timer_two_count_pin = 1'h1;
  logic        i_timer_one_overflow = 1'h0;
  logic [1:0]  i_serial_mode = 2'h0;
  logic        i_framing_error_set = 1'h0;
  logic        i_rx_byte_valid = 1'h0;
  logic [7:0]  i_rx_byte = 8'h00;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [1:0]  o_avs_response;
  logic [7:0]  o_tx_byte;
  logic        o_tx_load;
  logic        o_tx_baud_tick;
  logic        o_rx_baud_tick;
  logic        o_baud_doubling;
  logic        o_timer_two_irq;
  int          errors = 0;
  int          checked = 0;
  int          t1c = 0;
  ubt_core ubt_core_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .i_timer_two_trigger_pin(i_timer_two_trigger_pin), .i_timer_two_count_pin(i_timer_two_count_pin),
    .i_timer_one_overflow(i_timer_one_overflow), .i_serial_mode(i_serial_mode), .i_rx_byte(i_rx_byte),
    .i_framing_error_set(i_framing_error_set), .i_rx_byte_valid(i_rx_byte_valid), .o_tx_byte(o_tx_byte),
    .o_tx_load(o_tx_load), .o_tx_baud_tick(o_tx_baud_tick), .o_rx_baud_tick(o_rx_baud_tick),
    .o_baud_doubling(o_baud_doubling), .o_timer_two_irq(o_timer_two_irq));
  always #4 i_mclk = ~i_mclk;
  // Timer one overflows every fifth cycle, so any window of 40 cycles holds exactly 8 of them.
  always @(posedge i_mclk) begin
    t1c <= (t1c + 1) % 5;
    i_timer_one_overflow <= (t1c == 4);
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // The request stands until waitrequest is sampled low; read data are taken at that same edge.
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q,
                     output logic [1:0] r);
    i_avs_address <= a;
    i_avs_writedata <= {24'h000000, d};
    i_avs_write <= w;
    i_avs_read <= !w;
    do begin
      @(posedge i_mclk);
    end while (o_avs_waitrequest !== 1'h0);
    q = o_avs_readdata[7:0];
    r = o_avs_response;
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
    @(posedge i_mclk);
  endtask : bus
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] q;
    logic [1:0] r;
    bus(1'h1, {i, 2'h0}, d, q, r);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] i, input logic [7:0] exp, input logic [7:0] m);
    logic [7:0] q;
    logic [1:0] r;
    bus(1'h0, {i, 2'h0}, 8'h00, q, r);
    chk(nm, {8'h00, exp}, {8'h00, q & m});
  endtask : rdc
  task automatic fall(input logic cnt);
    if (cnt)
      i_timer_two_count_pin <= 1'h0;
    else
      i_timer_two_trigger_pin <= 1'h0;
    repeat (6) @(posedge i_mclk);
    i_timer_two_count_pin <= 1'h1;
    i_timer_two_trigger_pin <= 1'h1;
    repeat (6) @(posedge i_mclk);
  endtask : fall
  task automatic ticks(input int c, output int t, output int r);
    t = 0;
    r = 0;
    repeat (c) begin
      @(negedge i_mclk);
      t += (o_tx_baud_tick === 1'h1);
      r += (o_rx_baud_tick === 1'h1);
    end
  endtask : ticks
  task automatic t_regs;
    logic [7:0] q;
    logic [1:0] r;
    rdc("reload rst", RLV, 8'h00, 8'hFF);
    rdc("t2c rst", T2C, 8'h00, 8'hFF);
    wr(RLV, 8'hA5);
    rdc("reload", RLV, 8'hA5, 8'hFF);
    bus(1'h0, 10'h3FC, 8'h00, q, r);
    chk("unmapped", 16'h0300, {6'h00, r, q});
    bus(1'h1, {RLV, 2'h1}, 8'h3C, q, r);
    rdc("misaligned", RLV, 8'hA5, 8'hFF);
  endtask : t_regs
  task automatic t_timer;
    logic [7:0] q;
    logic [1:0] r;
    int t;
    int x;
    wr(CNL, 8'hFE);
    wr(CNL + 8'h01, 8'hFF);
    wr(T2C, 8'h04);
    repeat (6) @(posedge i_mclk);
    rdc("ovf flag", T2C, 8'h84, 8'hFF);
    chk("ovf irq", 16'h0001, {15'h0000, o_timer_two_irq});
    wr(T2C, 8'h00);
    bus(1'h0, {CNL, 2'h0}, 8'h00, q, r);
    repeat (8) @(posedge i_mclk);
    rdc("stopped", CNL, q, 8'hFF);
    rdc("flag clr", T2C, 8'h00, 8'hFF);
    wr(RLL, 8'hFE);
    wr(RLL + 8'h01, 8'hFF);
    i_serial_mode <= 2'h1;
    wr(CNL, 8'hFE);
    wr(CNL + 8'h01, 8'hFF);
    wr(T2C, 8'h25);
    ticks(40, t, x);
    chk("rx from t2", 16'h0001, {15'h0000, x >= 10});
    chk("tx from t1", 16'h0008, t[15:0]);
    rdc("no ovf flag", T2C, 8'h25, 8'hFF);
    wr(T2C, 8'h00);
  endtask : t_timer
  task automatic t_trigger;
    wr(CNL, 8'h34);
    wr(CNL + 8'h01, 8'h12);
    wr(T2C, 8'h09);
    fall(1'h0);
    rdc("capture", RLL, 8'h34, 8'hFF);
    rdc("ext flag", T2C, 8'h49, 8'hFF);
    chk("ext irq", 16'h0001, {15'h0000, o_timer_two_irq});
    wr(MEX, 8'h01);
    chk("updown irq", 16'h0000, {15'h0000, o_timer_two_irq});
    wr(MEX, 8'h00);
    wr(RLL, 8'h78);
    wr(T2C, 8'h08);
    fall(1'h0);
    rdc("reload", CNL, 8'h78, 8'hFF);
    wr(T2C, 8'h00);
    wr(CNL, 8'h11);
    fall(1'h0);
    rdc("ignored", CNL, 8'h11, 8'hFF);
    rdc("no ext", T2C, 8'h00, 8'hFF);
    wr(CNL, 8'h00);
    wr(T2C, 8'h06);
    repeat (3) fall(1'h1);
    rdc("count pin", CNL, 8'h03, 8'hFF);
    wr(T2C, 8'h00);
  endtask : t_trigger
  task automatic t_gen;
    int f;
    int s;
    int t;
    int x;
    wr(RLV, 8'hFC);
    wr(GEN, 8'h1A);
    ticks(40, f, x);
    wr(GEN, 8'h18);
    ticks(40, s, x);
    chk("fast slow", 16'h0001, {15'h0000, f > s && s > 0});
    wr(GEN, 8'h14);
    ticks(40, t, x);
    chk("rx gen", 16'h0001, {15'h0000, x > 0 && t == 8});
    wr(GEN, 8'h0C);
    ticks(40, t, x);
    chk("gen off", 16'h0000, t[15:0] + x[15:0]);
    i_serial_mode <= 2'h0;
    wr(GEN, 8'h00);
    ticks(120, t, x);
    chk("m0 std", 16'h0001, {15'h0000, (t - 120 / ubt_pkg::M0_DIV_STD) inside {[-1:1]}});
    wr(MEX, 8'h02);
    ticks(120, t, x);
    chk("m0 x2", 16'h0001, {15'h0000, (t - 120 / ubt_pkg::M0_DIV_X2) inside {[-1:1]}});
    wr(GEN, 8'h01);
    ticks(120, t, x);
    chk("m0 gen", 16'h0000, t[15:0]);
    wr(GEN, 8'h00);
    wr(MEX, 8'h00);
  endtask : t_gen
  task automatic t_serial;
    i_serial_mode <= 2'h1;
    wr(PMC, 8'h80);
    chk("doubling", 16'h0001, {15'h0000, o_baud_doubling});
    i_framing_error_set <= 1'h1;
    @(posedge i_mclk);
    i_framing_error_set <= 1'h0;
    rdc("sm0 view", SCR, 8'h00, 8'h80);
    wr(PMC, 8'hC0);
    rdc("fe view", SCR, 8'h80, 8'h80);
    wr(SCR, 8'h00);
    rdc("fe clr", SCR, 8'h00, 8'h80);
    wr(PMC, 8'h00);
    i_rx_byte <= 8'h3C;
    i_rx_byte_valid <= 1'h1;
    @(posedge i_mclk);
    i_rx_byte_valid <= 1'h0;
    rdc("rx buf", ubt_pkg::SERIAL_BUFFER_IDX, 8'h3C, 8'hFF);
    wr(ubt_pkg::SERIAL_BUFFER_IDX, 8'hA7);
    chk("tx byte", 16'h00A7, {8'h00, o_tx_byte});
  endtask : t_serial
  task automatic end_of_test;
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'h0;
    @(posedge i_mclk);
    t_regs;
    t_timer;
    t_trigger;
    t_gen;
    t_serial;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    errors++;
    end_of_test;
  end
endmodule : tb
